// >>> mhs_semaphore.sv
// Hardware semaphore unit: 32 flags shared by three cores, direct/indirect/combined modes.
// Assumes requests come from logic on CLK; one request per core per cycle, arbitrated by core index.
`timescale 1ns/10ps
`default_nettype none

module mhs_semaphore
    import mhs_pkg::*;
#(
    parameter int N_CORES = NUM_CORES,
    parameter int N_SEMS = NUM_SEMS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Requests, one lane per core
    input wire logic [N_CORES-1:0] REQ_VALID,
    input wire logic [N_CORES*2-1:0] REQ_MODE,
    input wire logic [N_CORES*SEM_IDX_W-1:0] REQ_SEM,
    // Answers, one lane per core
    output logic [N_CORES-1:0] RSP_VALID,
    output logic [N_CORES-1:0] RSP_GRANTED,
    output logic [N_CORES-1:0] RSP_QUEUED,
    // Notify flag clear, per core
    input wire logic [N_CORES-1:0] NOTIFY_CLR_VALID,
    input wire logic [N_CORES*SEM_IDX_W-1:0] NOTIFY_CLR_SEM,
    // Status
    output logic [N_CORES*N_SEMS-1:0] NOTIFY_FLAGS,
    output logic [N_CORES-1:0] SEM_IRQ,
    output logic [N_SEMS-1:0] SEM_BUSY
);

    logic [CORE_W-1:0] owner_reg [N_SEMS];
    logic [CORE_W-1:0] q0_reg [N_SEMS];
    logic [CORE_W-1:0] q1_reg [N_SEMS];
    logic [CORE_W-1:0] owner_next [N_SEMS];
    logic [CORE_W-1:0] q0_next [N_SEMS];
    logic [CORE_W-1:0] q1_next [N_SEMS];
    logic [N_CORES*N_SEMS-1:0] notify_reg;
    logic [N_CORES*N_SEMS-1:0] notify_set;
    logic [N_CORES-1:0] rsp_valid_reg;
    logic [N_CORES-1:0] rsp_granted_reg;
    logic [N_CORES-1:0] rsp_queued_reg;
    logic [N_CORES-1:0] rsp_valid_next;
    logic [N_CORES-1:0] rsp_granted_next;
    logic [N_CORES-1:0] rsp_queued_next;
    logic [N_SEMS-1:0] busy_reg;

    // serialised per cycle
    // Cores are processed in index order within one cycle, so each sees the
    // state left by lower-index cores; the whole test-and-set is one update.
    always_comb begin
        mhs_mode_e mode;
        logic [SEM_IDX_W-1:0] s;
        logic [CORE_W-1:0] core_id;
        mode = MHS_MODE_DIRECT;
        s = '0;
        core_id = '0;
        notify_set = '0;
        rsp_valid_next = '0;
        rsp_granted_next = '0;
        rsp_queued_next = '0;
        for (int i = 0; i < N_SEMS; i++) begin
            owner_next[i] = owner_reg[i];
            q0_next[i] = q0_reg[i];
            q1_next[i] = q1_reg[i];
        end
        for (int c = 0; c < N_CORES; c++) begin
            mode = mhs_mode_e'(REQ_MODE[c*2 +: 2]);
            s = REQ_SEM[c*SEM_IDX_W +: SEM_IDX_W];
            core_id = CORE_W'(c);
            if (REQ_VALID[c]) begin
                rsp_valid_next[c] = 1'b1;
                if (mode == MHS_MODE_RELEASE) begin
                    if (owner_next[s] == core_id) begin
                        owner_next[s] = q0_next[s];
                        q0_next[s] = q1_next[s];
                        q1_next[s] = CORE_NONE;
                        if (q0_next[s] != CORE_NONE || owner_next[s] != CORE_NONE) begin
                            if (owner_next[s] != CORE_NONE) begin
                                notify_set[int'(owner_next[s])*N_SEMS + int'(s)] = 1'b1;
                            end
                        end
                    end
                end else if (owner_next[s] == CORE_NONE) begin
                    if (mode != MHS_MODE_INDIRECT) begin
                        owner_next[s] = core_id;
                        rsp_granted_next[c] = 1'b1;
                    end else begin
                        owner_next[s] = core_id;
                        rsp_queued_next[c] = 1'b1;
                        notify_set[c*N_SEMS + int'(s)] = 1'b1;
                    end
                end else if (mode != MHS_MODE_DIRECT && owner_next[s] != core_id
                             && q0_next[s] != core_id && q1_next[s] != core_id) begin
                    if (q0_next[s] == CORE_NONE) begin
                        q0_next[s] = core_id;
                        rsp_queued_next[c] = 1'b1;
                    end else if (q1_next[s] == CORE_NONE) begin
                        q1_next[s] = core_id;
                        rsp_queued_next[c] = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < N_SEMS; i++) begin
                owner_reg[i] <= CORE_NONE;
                q0_reg[i] <= CORE_NONE;
                q1_reg[i] <= CORE_NONE;
            end
        end else begin
            for (int i = 0; i < N_SEMS; i++) begin
                owner_reg[i] <= owner_next[i];
                q0_reg[i] <= q0_next[i];
                q1_reg[i] <= q1_next[i];
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            notify_reg <= '0;
        end else begin
            for (int c = 0; c < N_CORES; c++) begin
                for (int i = 0; i < N_SEMS; i++) begin
                    if (notify_set[c*N_SEMS + i]) begin
                        notify_reg[c*N_SEMS + i] <= 1'b1;
                    end else if (NOTIFY_CLR_VALID[c]
                                 && int'(NOTIFY_CLR_SEM[c*SEM_IDX_W +: SEM_IDX_W]) == i) begin
                        notify_reg[c*N_SEMS + i] <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rsp_valid_reg <= '0;
            rsp_granted_reg <= '0;
            rsp_queued_reg <= '0;
        end else begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_granted_reg <= rsp_granted_next;
            rsp_queued_reg <= rsp_queued_next;
        end
    end

    assign RSP_VALID = rsp_valid_reg;
    assign RSP_GRANTED = rsp_granted_reg;
    assign RSP_QUEUED = rsp_queued_reg;
    assign NOTIFY_FLAGS = notify_reg;

    always_comb begin
        for (int c = 0; c < N_CORES; c++) begin
            SEM_IRQ[c] = |notify_reg[c*N_SEMS +: N_SEMS];
        end
    end

    // per-flag busy view
    // Taken from the next owner so it moves on the same edge as the owner
    // table, with no compare tree in front of the output pin.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            busy_reg <= '0;
        end else begin
            for (int i = 0; i < N_SEMS; i++) begin
                busy_reg[i] <= (owner_next[i] != CORE_NONE);
            end
        end
    end

    assign SEM_BUSY = busy_reg;

    // Checks below name lanes 0 to 2 directly, so they assume three cores.

    AST_DIRECT_HELD_NO_GRANT: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID[0] && REQ_MODE[1:0] == MHS_MODE_DIRECT && SEM_BUSY[REQ_SEM[4:0]]
        |=> RSP_VALID[0] && !RSP_GRANTED[0] && !RSP_QUEUED[0])
        else $error("direct request on held semaphore changed state");
    AST_FREE_GRANT: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID[0] && REQ_MODE[1:0] != MHS_MODE_INDIRECT && REQ_MODE[1:0] != MHS_MODE_RELEASE
        && !SEM_BUSY[REQ_SEM[4:0]] |=> RSP_GRANTED[0] ##0 SEM_BUSY[$past(REQ_SEM[4:0])])
        else $error("free semaphore not granted to core 0");
    AST_COMBINED_QUEUES: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID[1:0] == 2'h2 && REQ_MODE[3:2] == MHS_MODE_COMBINED && owner_reg[REQ_SEM[9:5]] == 2'h0
        && q0_reg[REQ_SEM[9:5]] == CORE_NONE
        |=> RSP_VALID[1] && RSP_QUEUED[1] && !RSP_GRANTED[1] && q0_reg[$past(REQ_SEM[9:5])] == 2'h1)
        else $error("combined request on held semaphore not queued");
    AST_RESET_CLEAR: assert property (@(posedge CLK)
        RESET |=> SEM_IRQ == '0 && SEM_BUSY == '0 && RSP_VALID == '0)
        else $error("state not clear after reset");
    AST_IRQ_FROM_FLAG: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID[1:0] == 2'h1 && REQ_MODE[1:0] == MHS_MODE_RELEASE && owner_reg[REQ_SEM[4:0]] == 2'h0
        && q0_reg[REQ_SEM[4:0]] == 2'h1 && !NOTIFY_CLR_VALID[2]
        |=> SEM_IRQ[1] && NOTIFY_FLAGS[N_SEMS + int'($past(REQ_SEM[4:0]))]
        && NOTIFY_FLAGS[2*N_SEMS + int'($past(REQ_SEM[4:0]))]
        == $past(NOTIFY_FLAGS[2*N_SEMS + int'(REQ_SEM[4:0])]))
        else $error("release hand-over did not notify only the new owner");
    AST_ONE_GRANT_PER_SEM: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID[1:0] == 2'h3 && REQ_SEM[4:0] == REQ_SEM[9:5] && REQ_MODE[3:0] == 4'h0
        |=> !(RSP_GRANTED[0] && RSP_GRANTED[1]))
        else $error("two cores granted one semaphore");
    AST_ANSWER_NEXT: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID[2] |=> RSP_VALID[2])
        else $error("request without answer");
    AST_RELEASE_KEEPS_BUSY: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID == 3'h1 && REQ_MODE[1:0] == MHS_MODE_RELEASE && owner_reg[REQ_SEM[4:0]] == 2'h0
        && q0_reg[REQ_SEM[4:0]] != CORE_NONE
        |=> SEM_BUSY[$past(REQ_SEM[4:0])] && owner_reg[$past(REQ_SEM[4:0])] == $past(q0_reg[REQ_SEM[4:0]])
        && q0_reg[$past(REQ_SEM[4:0])] == $past(q1_reg[REQ_SEM[4:0]]))
        else $error("release did not pass ownership to the oldest waiter");

    AST_INDIRECT_FREE_NOTIFY: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID[1:0] == 2'h2 && REQ_MODE[3:2] == MHS_MODE_INDIRECT && !SEM_BUSY[REQ_SEM[9:5]]
        |=> RSP_QUEUED[1] && !RSP_GRANTED[1] && SEM_IRQ[1] && NOTIFY_FLAGS[N_SEMS + int'($past(REQ_SEM[9:5]))])
        else $error("indirect request on free semaphore not notified");

    AST_QUEUE_FULL_REFUSED: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID[0] && REQ_MODE[1:0] == MHS_MODE_INDIRECT && q1_reg[REQ_SEM[4:0]] != CORE_NONE
        |=> RSP_VALID[0] && !RSP_QUEUED[0] && !RSP_GRANTED[0])
        else $error("request taken into a full queue");

    AST_NO_WITHDRAW: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID == 3'h4 && REQ_MODE[5:4] == MHS_MODE_RELEASE && owner_reg[REQ_SEM[14:10]] != 2'h2
        |=> owner_reg[$past(REQ_SEM[14:10])] == $past(owner_reg[REQ_SEM[14:10]])
        && q0_reg[$past(REQ_SEM[14:10])] == $past(q0_reg[REQ_SEM[14:10]])
        && q1_reg[$past(REQ_SEM[14:10])] == $past(q1_reg[REQ_SEM[14:10]]))
        else $error("queued request withdrawn by a release");

    AST_RELEASE_FREES: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID == 3'h4 && REQ_MODE[5:4] == MHS_MODE_RELEASE && owner_reg[REQ_SEM[14:10]] == 2'h2
        && q0_reg[REQ_SEM[14:10]] == CORE_NONE
        |=> !SEM_BUSY[$past(REQ_SEM[14:10])])
        else $error("release by sole owner left semaphore held");

    AST_IDLE_HOLDS: assert property (@(posedge CLK) disable iff (RESET)
        REQ_VALID == '0 |=> $stable(SEM_BUSY))
        else $error("semaphore state changed without a request");

    // Main scenarios: free grant, queueing, hand-over, same-cycle contention
    COV_DIRECT_GRANT: cover property (@(posedge CLK) RSP_GRANTED[0]);
    COV_QUEUED: cover property (@(posedge CLK) RSP_QUEUED[1]);
    COV_IRQ: cover property (@(posedge CLK) SEM_IRQ[2]);
    COV_HANDOVER: cover property (@(posedge CLK) disable iff (RESET) $rose(SEM_IRQ[1]));
    COV_CONTENTION: cover property (@(posedge CLK) RSP_GRANTED[0] && RSP_QUEUED[2]);

endmodule : mhs_semaphore

`default_nettype wire

// >>> mhs_pkg.sv
// Package for the multicore hardware semaphore unit.
// Assumes a single clock domain and plain-port request interfaces.
package mhs_pkg;
    localparam int NUM_CORES = 3;
    localparam int NUM_SEMS = 32;
    localparam int SEM_IDX_W = 5;
    localparam int CORE_W = 2;
    localparam int QUEUE_DEPTH = 2;
    localparam logic [CORE_W-1:0] CORE_NONE = 2'h3;

    typedef enum logic [1:0] {
        MHS_MODE_DIRECT = 2'h0,
        MHS_MODE_INDIRECT = 2'h1,
        MHS_MODE_COMBINED = 2'h2,
        MHS_MODE_RELEASE = 2'h3
    } mhs_mode_e;
endpackage : mhs_pkg

// >>> mhs_core_model.sv
// Model of the three cores that issue semaphore requests and clear notify flags.
// Assumes the unit takes requests on rising CLK and answers one cycle later.
`timescale 1ns/10ps
`default_nettype none
module mhs_core_model
    import mhs_pkg::*;
(
    // Clock
    input wire logic CLK,
    // Request lanes
    output logic [2:0] REQ_VALID,
    output logic [5:0] REQ_MODE,
    output logic [14:0] REQ_SEM,
    // Answer lanes
    input wire logic [2:0] RSP_VALID,
    input wire logic [2:0] RSP_GRANTED,
    input wire logic [2:0] RSP_QUEUED,
    // Notify clear lanes
    output logic [2:0] NOTIFY_CLR_VALID,
    output logic [14:0] NOTIFY_CLR_SEM
);
    initial begin
        REQ_VALID = 3'h0;
        REQ_MODE = 6'h0;
        REQ_SEM = 15'h0;
        NOTIFY_CLR_VALID = 3'h0;
        NOTIFY_CLR_SEM = 15'h0;
    end

    // one lane per core
    // Released lanes show inverted values so stale data cannot pass for a request
    task issue(input logic [2:0] v, input logic [5:0] m, input logic [14:0] s,
               output logic [2:0] rv, output logic [2:0] rg, output logic [2:0] rq);
        @(negedge CLK);
        REQ_VALID = v;
        REQ_MODE = m;
        REQ_SEM = s;
        @(negedge CLK);
        rv = RSP_VALID;
        rg = RSP_GRANTED;
        rq = RSP_QUEUED;
        REQ_VALID = 3'h0;
        REQ_MODE = ~m;
        REQ_SEM = ~s;
    endtask : issue

    task clr(input logic [2:0] v, input logic [14:0] s);
        @(negedge CLK);
        NOTIFY_CLR_VALID = v;
        NOTIFY_CLR_SEM = s;
        @(negedge CLK);
        NOTIFY_CLR_VALID = 3'h0;
        NOTIFY_CLR_SEM = ~s;
    endtask : clr
endmodule : mhs_core_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the semaphore unit.
// Assumes the core model drives all request and clear lanes.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import mhs_pkg::*;
    logic clk, reset;
    logic [2:0] req_v, rsp_v, rsp_g, rsp_q, clr_v, irq, rv, rg, rq;
    logic [5:0] req_m;
    logic [14:0] req_s, clr_s;
    logic [95:0] flags;
    logic [31:0] busy;
    int error_cnt, n_compared, cyc;
    mhs_semaphore i_dut (.CLK(clk), .RESET(reset), .REQ_VALID(req_v), .REQ_MODE(req_m), .REQ_SEM(req_s),
        .RSP_VALID(rsp_v), .RSP_GRANTED(rsp_g), .RSP_QUEUED(rsp_q), .NOTIFY_CLR_VALID(clr_v),
        .NOTIFY_CLR_SEM(clr_s), .NOTIFY_FLAGS(flags), .SEM_IRQ(irq), .SEM_BUSY(busy));
    mhs_core_model i_cores (.CLK(clk), .REQ_VALID(req_v), .REQ_MODE(req_m), .REQ_SEM(req_s),
        .RSP_VALID(rsp_v), .RSP_GRANTED(rsp_g), .RSP_QUEUED(rsp_q), .NOTIFY_CLR_VALID(clr_v),
        .NOTIFY_CLR_SEM(clr_s));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input string what, input logic [95:0] exp, input logic [95:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    function automatic logic [95:0] fbit(input int c, input int s);
        return 96'h1 << (c * 32 + s);
    endfunction : fbit
    task req1(input int c, input mhs_mode_e m, input int s, input logic [2:0] eg, input logic [2:0] eq);
        i_cores.issue(3'h1 << c, 6'(m) << (2 * c), 15'(s) << (5 * c), rv, rg, rq);
        chk("rsp_valid", 96'(3'h1 << c), 96'(rv));
        chk("rsp_granted", 96'(eg), 96'(rg));
        chk("rsp_queued", 96'(eq), 96'(rq));
    endtask : req1
    task do_reset;
        @(negedge clk);
        reset = 1'b1;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        chk("busy", 96'h0, 96'(busy));
        chk("flags", 96'h0, flags);
        chk("irq", 96'h0, 96'(irq));
    endtask : do_reset
    task t_direct;
        req1(0, MHS_MODE_DIRECT, 5, 3'h1, 3'h0);
        req1(1, MHS_MODE_DIRECT, 5, 3'h0, 3'h0);
        chk("busy", 96'h20, 96'(busy));
    endtask : t_direct
    task t_queue;
        req1(1, MHS_MODE_COMBINED, 5, 3'h0, 3'h2);
        req1(2, MHS_MODE_INDIRECT, 5, 3'h0, 3'h4);
        req1(0, MHS_MODE_INDIRECT, 5, 3'h0, 3'h0);
        req1(2, MHS_MODE_RELEASE, 5, 3'h0, 3'h0);
        chk("flags", 96'h0, flags);
    endtask : t_queue
    task t_handover;
        req1(0, MHS_MODE_RELEASE, 5, 3'h0, 3'h0);
        chk("flags", fbit(1, 5), flags);
        chk("irq", 96'h2, 96'(irq));
        chk("busy", 96'h20, 96'(busy));
        req1(0, MHS_MODE_DIRECT, 5, 3'h0, 3'h0);
        i_cores.clr(3'h2, 15'h5 << 5);
        chk("irq", 96'h0, 96'(irq));
        req1(1, MHS_MODE_RELEASE, 5, 3'h0, 3'h0);
        chk("flags", fbit(2, 5), flags);
        chk("irq", 96'h4, 96'(irq));
        i_cores.clr(3'h4, 15'h5 << 10);
        req1(2, MHS_MODE_RELEASE, 5, 3'h0, 3'h0);
        chk("busy", 96'h0, 96'(busy));
    endtask : t_handover
    task t_arbit;
        i_cores.issue(3'h7, 6'h00, 15'h7FFF, rv, rg, rq);
        chk("granted", 96'h1, 96'(rg));
        i_cores.issue(3'h7, 6'h2A, 15'h0, rv, rg, rq);
        chk("granted", 96'h1, 96'(rg));
        chk("queued", 96'h6, 96'(rq));
        chk("busy", 96'h80000001, 96'(busy));
        req1(1, MHS_MODE_INDIRECT, 9, 3'h0, 3'h2);
        chk("flags", fbit(1, 9), flags);
    endtask : t_arbit
    task results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == 2000) begin
                error_cnt++;
                results();
            end
        end
    end
    initial begin
        error_cnt = 0;
        n_compared = 0;
        reset = 1'b1;
        do_reset();
        t_direct();
        t_queue();
        t_handover();
        t_arbit();
        do_reset();
        results();
    end
endmodule : tb_top
`default_nettype wire
